//--- hdl/bpl_core.v
`include "bpl_consts.vh"

// Burst publishing, lock control and dynamic variable mapping
module bpl_core
#(
	parameter [31:0] SEC_CYCLES = `BPL_SEC_CYCLES
)
(
	input  wire        clk,
	input  wire        rstn,
	// Configuration writes from the master
	input  wire        cfg_wr,
	input  wire        cfg_master,     // 0 primary, 1 secondary
	input  wire        burst_enable,
	input  wire [7:0]  burst_cmd_req,
	input  wire [2:0]  trigger_mode_req,
	input  wire [15:0] trigger_level_req,
	input  wire [11:0] min_period_req,
	input  wire [11:0] max_period_req,
	input  wire        slot_wr,
	input  wire [2:0]  slot_index,
	input  wire [3:0]  slot_code,
	input  wire        map_wr,
	input  wire [1:0]  map_which,      // 0 PV, 1 SV, 2 TV, 3 QV
	input  wire [3:0]  map_code,
	input  wire        lock_wr,
	input  wire [1:0]  lock_action,
	input  wire        local_cfg_req,
	input  wire        tag_wr,
	input  wire [4:0]  tag_addr,
	input  wire [7:0]  tag_char,
	input  wire        protocol_revision_select,
	// Stored lock state restored from persistent storage
	input  wire [1:0]  nv_lock_state,
	input  wire        nv_lock_owner,
	// Device variables
	input  wire [15:0] pressure_value,
	input  wire [15:0] process_percent,
	input  wire [15:0] setpoint_percent,
	input  wire [159:0] dev_var_flat,   // Ten 16-bit device variables
	// Outputs, plus the tag read address input
	output reg         burst_pulse,
	output reg  [7:0]  burst_cmd,
	output reg  [3:0]  burst_slot_count,
	output reg         burst_with_status,
	output reg  [63:0] burst_codes_flat,
	output reg  [15:0] trigger_source,
	output reg  [11:0] active_period,
	output reg         cfg_accepted,
	output reg         cfg_refused,
	output reg  [1:0]  lock_state,
	output reg         lock_owner,
	output reg         nv_save,
	output reg  [1:0]  nv_state_out,
	output reg         nv_owner_out,
	output reg         local_blocked,
	output reg  [3:0]  pv_code,
	output reg  [3:0]  sv_code,
	output reg  [3:0]  tv_code,
	output reg  [3:0]  qv_code,
	output reg  [15:0] control_error,
	output reg  [7:0]  tag_read_char,
	input  wire [4:0]  tag_read_addr
);

	////////////////////////////////////////////////////////////////////////////////
	// Reset synchroniser
	reg        rst_meta;
	reg        rst_sync;
	wire       rst_n = rst_sync;

	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			rst_meta <= 1'b0;
			rst_sync <= 1'b0;
		end
		else
		begin
			rst_meta <= 1'b1;
			rst_sync <= rst_meta;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Configuration permission
	wire       write_any = cfg_wr | slot_wr | map_wr | tag_wr;
	// [RQ16] [RQ17] [RQ18] lock gating
	wire       cfg_locked = (lock_state == `BPL_LK_ALL) ||
	                        ((lock_state != `BPL_LK_NONE) && (lock_owner != cfg_master));
	wire       cfg_ok = write_any & ~cfg_locked;
	wire       unlock_ok = lock_state == `BPL_LK_ALL || lock_state == `BPL_LK_NONE || lock_owner == cfg_master;

	// [RQ1] valid burst command check
	wire       cmd_valid = (burst_cmd_req == `BPL_CMD_1) || (burst_cmd_req == `BPL_CMD_2) ||
	                       (burst_cmd_req == `BPL_CMD_3) || (burst_cmd_req == `BPL_CMD_9) ||
	                       (burst_cmd_req == `BPL_CMD_33) || (burst_cmd_req == `BPL_CMD_48);
	// [RQ11] window level must be positive
	wire       level_ok = (trigger_mode_req != `BPL_TRG_WINDOW) ||
	                      (!trigger_level_req[15] && (trigger_level_req != 16'h0000));
	wire       mode_ok = (trigger_mode_req <= `BPL_TRG_CHANGE);

	wire [11:0] min_snap;
	wire [11:0] max_snap;

	bpl_period_snap u_snap_min
	(
		.req     (min_period_req),
		.snapped (min_snap)
	);

	bpl_period_snap u_snap_max
	(
		.req     (max_period_req),
		.snapped (max_snap)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Burst configuration storage
	reg        burst_on;
	reg [2:0]  trig_mode;
	reg [15:0] trig_level;
	reg [11:0] min_period;
	reg [11:0] max_period;
	reg [3:0]  slot_mem [0:7];

	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			burst_on   <= 1'b0;
			burst_cmd  <= `BPL_CMD_1;
			trig_mode  <= `BPL_TRG_CONT;
			trig_level <= 16'h0000;
			min_period <= `BPL_PER_ONE;
			max_period <= `BPL_PER_ONE;
		end
		else if (cfg_wr && !cfg_locked && cmd_valid && level_ok && mode_ok)
		begin
			burst_on   <= burst_enable;
			burst_cmd  <= burst_cmd_req;
			trig_mode  <= trigger_mode_req;
			trig_level <= trigger_level_req;
			min_period <= min_snap;
			// [RQ7] keep minimum not above maximum
			max_period <= (max_snap < min_snap) ? min_snap : max_snap;
		end
	end

	// Slot codes, one generate entry each
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi = gi + 1)
		begin : g_slot
			localparam [31:0] SLOT_K = gi;
			always @(posedge clk or negedge rst_n)
			begin
				if (!rst_n)
					slot_mem[gi] <= SLOT_K[3:0];
				else if (slot_wr && !cfg_locked && slot_index == SLOT_K[2:0] && slot_code < `BPL_VAR_COUNT)
					slot_mem[gi] <= slot_code;
			end
		end
	endgenerate

	// Slot list out and frame shape
	integer si;
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			burst_codes_flat  <= 64'h0;
			burst_slot_count  <= 4'h0;
			burst_with_status <= 1'b0;
		end
		else
		begin
			for (si = 0; si < 8; si = si + 1)
				burst_codes_flat[si*8 +: 8] <= {4'h0, slot_mem[si]};
			// [RQ3] eight slots with status
			// [RQ4] command 33 four slots
			if (burst_cmd == `BPL_CMD_9)
				burst_slot_count <= `BPL_SLOTS;
			else if (burst_cmd == `BPL_CMD_33)
				burst_slot_count <= `BPL_SLOTS_33;
			else
				burst_slot_count <= 4'h0;
			burst_with_status <= (burst_cmd == `BPL_CMD_9);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Trigger evaluation
	// [RQ5] slot zero source select
	wire [15:0] src = dev_var_flat[slot_mem[0]*16 +: 16];
	reg  [15:0] last_pub;
	wire signed [16:0] lo_band = $signed({last_pub[15], last_pub}) - $signed({trig_level[15], trig_level});
	wire signed [16:0] hi_band = $signed({last_pub[15], last_pub}) + $signed({trig_level[15], trig_level});
	wire signed [16:0] src_s   = $signed({src[15], src});
	reg         trig_met;

	always @*
	begin
		case (trig_mode)
			// [RQ10] continuous always met
			`BPL_TRG_CONT:    trig_met = 1'b1;
			// [RQ23] outside window band
			`BPL_TRG_WINDOW:  trig_met = (src_s > hi_band) || (src_s < lo_band);
			// [RQ12] above level
			`BPL_TRG_RISING:  trig_met = $signed(src) > $signed(trig_level);
			// [RQ13] below level
			`BPL_TRG_FALLING: trig_met = $signed(src) < $signed(trig_level);
			// [RQ14] differs from last
			`BPL_TRG_CHANGE:  trig_met = (src != last_pub);
			default:          trig_met = 1'b1;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Period timer: seconds prescaler and seconds counter
	reg [31:0] pre_cnt;
	reg [11:0] sec_cnt;
	wire       sec_tick = (pre_cnt == SEC_CYCLES - 32'h1);
	// [RQ6] pick min or max period
	wire [11:0] period_now = trig_met ? min_period : max_period;

	// [RQ2] unsolicited publishing
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pre_cnt        <= 32'h0;
			sec_cnt        <= 12'h000;
			burst_pulse    <= 1'b0;
			last_pub       <= 16'h0000;
			trigger_source <= 16'h0000;
			active_period  <= `BPL_PER_ONE;
		end
		else
		begin
			burst_pulse   <= 1'b0;
			active_period <= period_now;
			if (!burst_on)
			begin
				pre_cnt <= 32'h0;
				sec_cnt <= 12'h000;
			end
			else
			begin
				pre_cnt <= sec_tick ? 32'h0 : pre_cnt + 32'h1;
				if (sec_tick)
				begin
					if (sec_cnt + 12'h001 >= period_now)
					begin
						sec_cnt        <= 12'h000;
						burst_pulse    <= 1'b1;
						last_pub       <= src;
						trigger_source <= src;
					end
					else
						sec_cnt <= sec_cnt + 12'h001;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Lock state machine
	reg        restore_pending;

	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			lock_state      <= `BPL_LK_NONE;
			lock_owner      <= 1'b0;
			restore_pending <= 1'b1;
			nv_save         <= 1'b0;
			nv_state_out    <= `BPL_LK_NONE;
			nv_owner_out    <= 1'b0;
		end
		else
		begin
			nv_save <= 1'b0;
			if (restore_pending)
			begin
				// [RQ16] temporary lock cleared by reset
				// [RQ24] restore persistent lock
				restore_pending <= 1'b0;
				if (nv_lock_state == `BPL_LK_PERM || nv_lock_state == `BPL_LK_ALL)
				begin
					lock_state <= nv_lock_state;
					lock_owner <= nv_lock_owner;
				end
			end
			else if (lock_wr)
			begin
				case (lock_action)
					`BPL_ACT_UNLOCK:
					begin
						// [RQ15] entitled unlock only
						if (unlock_ok)
							lock_state <= `BPL_LK_NONE;
					end
					default:
					begin
						// New lock only when not held by another master
						if (!cfg_locked)
						begin
							lock_state <= lock_action;
							lock_owner <= cfg_master;
						end
					end
				endcase
			end
			// [RQ24] save persistent state
			if (lock_wr && !restore_pending)
			begin
				nv_save      <= 1'b1;
				nv_state_out <= (lock_action == `BPL_ACT_UNLOCK) ? (unlock_ok ? `BPL_LK_NONE : lock_state) :
				                cfg_locked ? lock_state : (lock_action == `BPL_LK_TEMP) ? `BPL_LK_NONE : lock_action;
				nv_owner_out <= cfg_locked ? lock_owner : cfg_master;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Accept or refuse answers, local panel block
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cfg_accepted  <= 1'b0;
			cfg_refused   <= 1'b0;
			local_blocked <= 1'b0;
		end
		else
		begin
			cfg_accepted  <= cfg_ok && !(map_wr && map_which == 2'h0);
			cfg_refused   <= write_any && (cfg_locked || (map_wr && map_which == 2'h0));
			// [RQ16] local panel blocked
			local_blocked <= local_cfg_req && (lock_state != `BPL_LK_NONE);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Dynamic variable mapping
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pv_code <= `BPL_VAR_PRESSURE;
			sv_code <= 4'h0;
			tv_code <= 4'h1;
			qv_code <= 4'h2;
		end
		else
		begin
			// [RQ19] primary fixed
			pv_code <= `BPL_VAR_PRESSURE;
			// [RQ20] remap secondary group
			if (map_wr && !cfg_locked && map_code < `BPL_VAR_COUNT)
			begin
				case (map_which)
					2'h1:    sv_code <= map_code;
					2'h2:    tv_code <= map_code;
					2'h3:    qv_code <= map_code;
					default: sv_code <= sv_code;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Control error
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			control_error <= 16'h0000;
		else
			// [RQ21] process minus setpoint
			control_error <= process_percent - setpoint_percent;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Long tag store
	reg [7:0] tag_mem [0:31];

	// [RQ22] long tag storage
	always @(posedge clk)
	begin
		if (tag_wr && !cfg_locked && protocol_revision_select)
			tag_mem[tag_addr] <= tag_char;
	end

	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			tag_read_char <= 8'h00;
		else
			tag_read_char <= tag_mem[tag_read_addr];
	end

endmodule

//--- pkg/bpl_consts.vh
// Operation
// [RQ1] Burst command limited to 1,2,3,9,33,48
// [RQ2] Publish unsolicited while burst enabled
// [RQ3] Command 9 reports eight slots with status
// [RQ4] Command 33 uses first four slots
// [RQ5] Slot zero value is trigger source
// [RQ6] Trigger met: minimum period, else maximum
// [RQ7] Master keeps minimum not above maximum
// [RQ8] Periods snapped to nearest permitted value
// [RQ9] Master supplies level for window/rise/fall
// [RQ10] Continuous mode always meets trigger
// [RQ11] Window level positive, band about last
// [RQ12] Rising publishes when source above level
// [RQ13] Falling publishes when source below level
// [RQ14] On-change publishes when source differs
// [RQ15] Unlock only by entitled master
// [RQ16] Temporary lock: owner unlocks, reset clears
// [RQ17] Permanent lock: owner unlocks, survives reset
// [RQ18] Lock-all blocks everyone, anyone clears
// [RQ19] Primary variable fixed to pressure
// [RQ20] Other dynamic variables freely mappable
// [RQ21] Control error is process minus setpoint
// [RQ22] Long tag up to 32 characters
// [RQ23] Window met when outside last plus/minus level
// [RQ24] Permanent lock state kept across reset
`ifndef BPL_CONSTS_VH
`define BPL_CONSTS_VH

////////////////////////////////////////////////////////////////////////////////
// Burst commands
`define BPL_CMD_1        8'h01
`define BPL_CMD_2        8'h02
`define BPL_CMD_3        8'h03
`define BPL_CMD_9        8'h09
`define BPL_CMD_33       8'h21
`define BPL_CMD_48       8'h30

// Slot counts
`define BPL_SLOTS        4'h8
`define BPL_SLOTS_33     4'h4
`define BPL_SLOT_W       3

// Trigger modes
`define BPL_TRG_CONT     3'h0
`define BPL_TRG_WINDOW   3'h1
`define BPL_TRG_RISING   3'h2
`define BPL_TRG_FALLING  3'h3
`define BPL_TRG_CHANGE   3'h4

// Lock actions and states
`define BPL_LK_NONE      2'h0
`define BPL_LK_TEMP      2'h1
`define BPL_LK_PERM      2'h2
`define BPL_LK_ALL       2'h3
`define BPL_ACT_UNLOCK   2'h0

// Device variable codes
`define BPL_VAR_PRESSURE 4'h4
`define BPL_VAR_COUNT    4'ha

// Period limits in seconds
`define BPL_PER_MAXSHORT 12'h020
`define BPL_PER_LONG_MIN 12'h03c
`define BPL_PER_LONG_MAX 12'he10
`define BPL_PER_ONE      12'h001

// Timing: one second at 100 MHz clock
`define BPL_CLK_MHZ      100
`define BPL_SEC_NS       1000000000
`define BPL_CLK_NS       10
`define BPL_SEC_CYCLES   (`BPL_SEC_NS / `BPL_CLK_NS)

// Long tag
`define BPL_TAG_LEN      6'h20
`define BPL_TAG_AW       5

`endif

//--- hdl/bpl_period_snap.v
`include "bpl_consts.vh"

// Snaps a requested period to the nearest permitted value
module bpl_period_snap
(
	input  wire [11:0] req,
	output reg  [11:0] snapped
);

	////////////////////////////////////////////////////////////////////////////////
	// Nearest of 1,2,4,8,16,32 or clamp into long range
	// [RQ8] period snapping
	always @*
	begin
		if (req <= `BPL_PER_ONE)
			snapped = `BPL_PER_ONE;
		else if (req >= `BPL_PER_LONG_MIN)
			snapped = (req > `BPL_PER_LONG_MAX) ? `BPL_PER_LONG_MAX : req;
		else if (req > 12'h02e)        // Midpoint of 32 and 60 is 46
			snapped = `BPL_PER_LONG_MIN;
		else if (req > 12'h018)        // Midpoint 16..32 is 24
			snapped = `BPL_PER_MAXSHORT;
		else if (req > 12'h00c)
			snapped = 12'h010;
		else if (req > 12'h006)
			snapped = 12'h008;
		else if (req > 12'h003)
			snapped = 12'h004;
		else
			snapped = 12'h002;     // 2 and 3 resolve to 2
	end

endmodule

//--- verification/bpl_core_monitor.sv
`include "bpl_consts.vh"

// Port-level checks of burst, lock and mapping behaviour
module bpl_monitor
(
	input wire        clk,
	input wire        rstn,
	input wire        cfg_wr,
	input wire        cfg_master,
	input wire        map_wr,
	input wire [1:0]  map_which,
	input wire [15:0] process_percent,
	input wire [15:0] setpoint_percent,
	input wire        burst_pulse,
	input wire [7:0]  burst_cmd,
	input wire [3:0]  burst_slot_count,
	input wire        burst_with_status,
	input wire [11:0] active_period,
	input wire        cfg_refused,
	input wire        cfg_accepted,
	input wire [1:0]  lock_state,
	input wire        lock_owner,
	input wire [3:0]  pv_code,
	input wire [15:0] control_error
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] up;

	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);

	////////////////////////////////////////////////////////////////////////////////
	// Cycles since reset release, covers the reset synchroniser
	always @(posedge clk or negedge rstn)
		if (!rstn)
			up <= 3'h0;
		else if (up != 3'h7)
			up <= up + 3'h1;

	cmd_legal_a: assert property (up == 3'h7 |-> burst_cmd inside {8'h01, 8'h02, 8'h03, 8'h09, 8'h21, 8'h30})
		else $error("burst command outside the legal set");
	period_legal_a: assert property (up == 3'h7 |-> active_period inside {12'h001, 12'h002, 12'h004, 12'h008,
		12'h010, 12'h020, [12'h03c:12'he10]})
		else $error("update period not a permitted value");
	slots_nine_a: assert property (up == 3'h7 && burst_cmd == 8'h09
		|=> burst_slot_count == 4'h8 && burst_with_status)
		else $error("command nine slot count or status wrong");
	slots_four_a: assert property (up == 3'h7 && burst_cmd == 8'h21 |=> burst_slot_count == 4'h4)
		else $error("command thirty-three slot count wrong");
	burst_gap_a: assert property (burst_pulse |=> !burst_pulse [*8])
		else $error("burst frames closer than one second");
	pv_fixed_a: assert property (up == 3'h7 |-> pv_code == `BPL_VAR_PRESSURE)
		else $error("primary variable not pressure");
	pv_remap_a: assert property (up == 3'h7 && map_wr && map_which == 2'h0 |-> ##[1:2] cfg_refused)
		else $error("primary remap not refused");
	lock_all_a: assert property (up == 3'h7 && cfg_wr && lock_state == `BPL_LK_ALL |-> ##[1:2] cfg_refused)
		else $error("write accepted under lock all");
	lock_other_a: assert property (up == 3'h7 && cfg_wr && cfg_master != lock_owner
		&& lock_state inside {`BPL_LK_TEMP, `BPL_LK_PERM} |-> ##[1:2] cfg_refused)
		else $error("write from other master accepted while locked");
	cfg_accept_a: assert property (up == 3'h7 && cfg_wr && !map_wr && lock_state == `BPL_LK_NONE
		|=> cfg_accepted)
		else $error("unlocked write not accepted");
	ctrl_error_a: assert property (up == 3'h7 && $stable(process_percent) && $stable(setpoint_percent)
		|=> control_error == 16'($past(process_percent) - $past(setpoint_percent)))
		else $error("control error not process minus setpoint");
endmodule

bind bpl_core bpl_monitor i_bpl_monitor (.clk, .rstn, .cfg_wr, .cfg_master, .map_wr, .map_which, .process_percent,
	.setpoint_percent, .burst_pulse, .burst_cmd, .burst_slot_count, .burst_with_status, .active_period, .cfg_refused,
	.lock_state, .lock_owner, .pv_code, .control_error, .cfg_accepted);

//--- verification/bpl_master_model.sv
// Field-bus master issuing configuration, slot, map, lock and tag writes
module bpl_master_model
(
	input  wire         clk,
	input  wire         cfg_refused,
	output logic        cfg_wr,
	output logic        cfg_master,
	output logic        burst_enable,
	output logic [7:0]  burst_cmd_req,
	output logic [2:0]  trigger_mode_req,
	output logic [15:0] trigger_level_req,
	output logic [11:0] min_period_req,
	output logic [11:0] max_period_req,
	output logic        slot_wr,
	output logic [2:0]  slot_index,
	output logic [3:0]  slot_code,
	output logic        map_wr,
	output logic [1:0]  map_which,
	output logic [3:0]  map_code,
	output logic        lock_wr,
	output logic [1:0]  lock_action,
	output logic        tag_wr,
	output logic [4:0]  tag_addr,
	output logic [7:0]  tag_char
);
	timeunit 1ns;
	timeprecision 1ps;
	logic got_ref;

	// Idle bus at time zero
	initial
		{cfg_wr, cfg_master, burst_enable, burst_cmd_req, trigger_mode_req, trigger_level_req, min_period_req,
			max_period_req, slot_wr, slot_index, slot_code, map_wr, map_which, map_code, lock_wr, lock_action,
			tag_wr, tag_addr, tag_char} = '0;

	// Strobe taken, dropped, answer gathered over two cycles
	task automatic finish_op;
		@(posedge clk);
		{cfg_wr, slot_wr, map_wr, lock_wr, tag_wr} <= 5'h0;
		got_ref = 1'b0;
		repeat (2)
		begin
			@(posedge clk);
			got_ref |= cfg_refused;
		end
	endtask

	// minimum not above maximum, level always sent
	task automatic cfg(input logic m, en, input logic [7:0] cmd, input logic [2:0] mode, input logic [15:0] lvl,
		input logic [11:0] mn, mx);
		@(posedge clk);
		{cfg_master, burst_enable, burst_cmd_req, trigger_mode_req, trigger_level_req, min_period_req, max_period_req,
			cfg_wr} <= {m, en, cmd, mode, lvl, mn, (mn > mx) ? mn : mx, 1'b1};
		finish_op;
	endtask

	task automatic slot(input logic [2:0] i, input logic [3:0] c);
		@(posedge clk);
		{cfg_master, slot_index, slot_code, slot_wr} <= {1'b0, i, c, 1'b1};
		finish_op;
	endtask

	task automatic map(input logic [1:0] w, input logic [3:0] c);
		@(posedge clk);
		{cfg_master, map_which, map_code, map_wr} <= {1'b0, w, c, 1'b1};
		finish_op;
	endtask

	task automatic lock(input logic m, input logic [1:0] a);
		@(posedge clk);
		{cfg_master, lock_action, lock_wr} <= {m, a, 1'b1};
		finish_op;
	endtask

	task automatic tag(input logic [4:0] a, input logic [7:0] ch);
		@(posedge clk);
		{tag_addr, tag_char, tag_wr} <= {a, ch, 1'b1};
		finish_op;
	endtask
endmodule

//--- verification/bpl_core_bench.sv
`include "bpl_consts.vh"

// Burst, lock, mapping and tag tests through the master model
module bpl_core_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic         clk, rstn, local_cfg_req, protocol_revision_select, nv_lock_owner;
	logic [1:0]   nv_lock_state;
	logic [4:0]   tag_read_addr;
	logic [15:0]  pressure_value, process_percent, setpoint_percent;
	logic [159:0] dev_var_flat;
	wire          cfg_wr, cfg_master, burst_enable, slot_wr, map_wr, lock_wr, tag_wr;
	wire  [7:0]   burst_cmd_req, tag_char, burst_cmd, tag_read_char;
	wire  [2:0]   trigger_mode_req, slot_index;
	wire  [15:0]  trigger_level_req, trigger_source, control_error;
	wire  [11:0]  min_period_req, max_period_req, active_period;
	wire  [3:0]   slot_code, map_code, burst_slot_count, pv_code, sv_code, tv_code, qv_code;
	wire  [1:0]   map_which, lock_action, lock_state, nv_state_out;
	wire  [4:0]   tag_addr;
	wire          burst_pulse, burst_with_status, cfg_accepted, cfg_refused, lock_owner, nv_save, nv_owner_out;
	wire          local_blocked;
	wire  [63:0]  burst_codes_flat;
	int           n_errors, compares, n;
	localparam logic [7:0]  CMDS [7] = '{8'h01, 8'h02, 8'h03, 8'h09, 8'h21, 8'h05, 8'h30};
	localparam logic [30:0] TRIG [4] = '{{3'h2, 16'h7000, 12'h03c}, {3'h2, 16'h0010, 12'h002},
		{3'h3, 16'h7000, 12'h002}, {3'h3, 16'h0010, 12'h03c}};

	bpl_core #(.SEC_CYCLES(32'd10)) i_bpl_core (.clk, .rstn, .cfg_wr, .cfg_master, .burst_enable, .burst_cmd_req,
		.trigger_mode_req, .trigger_level_req, .min_period_req, .max_period_req, .slot_wr, .slot_index, .slot_code,
		.map_wr, .map_which, .map_code, .lock_wr, .lock_action, .local_cfg_req, .tag_wr, .tag_addr, .tag_char,
		.protocol_revision_select, .nv_lock_state, .nv_lock_owner, .pressure_value, .process_percent,
		.setpoint_percent, .dev_var_flat, .burst_pulse, .burst_cmd, .burst_slot_count, .burst_with_status,
		.burst_codes_flat, .trigger_source, .active_period, .cfg_accepted, .cfg_refused, .lock_state, .lock_owner,
		.nv_save, .nv_state_out, .nv_owner_out, .local_blocked, .pv_code, .sv_code, .tv_code, .qv_code,
		.control_error, .tag_read_char, .tag_read_addr);
	bpl_master_model i_bpl_master_model (.clk, .cfg_refused, .cfg_wr, .cfg_master, .burst_enable, .burst_cmd_req,
		.trigger_mode_req, .trigger_level_req, .min_period_req, .max_period_req, .slot_wr, .slot_index, .slot_code,
		.map_wr, .map_which, .map_code, .lock_wr, .lock_action, .tag_wr, .tag_addr, .tag_char);

	// Clock at 100 MHz
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Persistent lock storage beside the device
	always @(posedge clk)
		if (nv_save === 1'b1)
			{nv_lock_state, nv_lock_owner} <= {nv_state_out, nv_owner_out};

	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic final_report;
		if (n_errors == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic do_reset;
		rstn <= 1'b0;
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		repeat (6) @(posedge clk);
	endtask

	// Cycles until the next burst frame, bounded
	task automatic wait_pulse(input int lim, output int cnt);
		cnt = 0;
		do
		begin
			@(posedge clk);
			cnt++;
		end
		while (burst_pulse !== 1'b1 && cnt < lim);
	endtask

	// Watchdog well above the expected run
	initial
	begin
		#200000;
		n_errors++;
		final_report;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		n_errors = 0;
		compares = 0;
		{rstn, local_cfg_req, protocol_revision_select, nv_lock_state, nv_lock_owner} = 6'h0;
		tag_read_addr = 5'h1f;
		{pressure_value, process_percent, setpoint_percent} = {16'h1234, 16'h0050, 16'h0020};
		for (int k = 0; k < 10; k++)
			dev_var_flat[16*k +: 16] = 16'(16'h0010 * k);
		do_reset;
		chk("pv_code", pv_code, `BPL_VAR_PRESSURE);
		chk("dyn codes", {sv_code, tv_code, qv_code}, 16'h0012);
		chk("lock_state", lock_state, `BPL_LK_NONE);
		chk("control_error", control_error, 16'h0030);
		i_bpl_master_model.map(2'h1, 4'h7);
		i_bpl_master_model.map(2'h3, 4'h9);
		chk("dyn codes", {sv_code, tv_code, qv_code}, 16'h0719);
		i_bpl_master_model.map(2'h0, 4'h5);
		chk("pv refused", {i_bpl_master_model.got_ref, pv_code}, 16'h0014);
		// Every burst command, one illegal one kept out
		for (int k = 0; k < 7; k++)
		begin
			i_bpl_master_model.cfg(1'b0, 1'b0, CMDS[k], `BPL_TRG_CONT, 16'h0, 12'h001, 12'h001);
			chk("burst_cmd", burst_cmd, (k == 5) ? 16'h0021 : CMDS[k]);
			chk("slot count", burst_slot_count,
				(CMDS[k] == 8'h09) ? 16'h8 : (CMDS[k] == 8'h21 || k == 5) ? 16'h4 : 16'h0);
		end
		i_bpl_master_model.slot(3'h0, 4'h3);
		i_bpl_master_model.cfg(1'b0, 1'b1, `BPL_CMD_9, `BPL_TRG_CONT, 16'h0, 12'h002, 12'h004);
		wait_pulse(100, n);
		chk("trigger_source", trigger_source, 16'h0030);
		chk("slot zero code", burst_codes_flat[7:0], 16'h0003);
		wait_pulse(100, n);
		chk("burst gap", 16'(n), 16'd20);
		// Rising and falling against the level, periods snapped
		for (int k = 0; k < 4; k++)
		begin
			i_bpl_master_model.cfg(1'b0, 1'b1, `BPL_CMD_9, TRIG[k][30:28], TRIG[k][27:12], 12'h003, 12'h032);
			repeat (25) @(posedge clk);
			chk("active_period", active_period, TRIG[k][11:0]);
		end
		i_bpl_master_model.cfg(1'b0, 1'b1, `BPL_CMD_33, `BPL_TRG_WINDOW, 16'h0, 12'h001, 12'h008);
		chk("window zero level", burst_cmd, `BPL_CMD_9);
		// Window then on-change: quiet while steady, fast after a step
		for (int k = 0; k < 2; k++)
		begin
			i_bpl_master_model.cfg(1'b0, 1'b1, `BPL_CMD_9, k ? `BPL_TRG_CHANGE : `BPL_TRG_WINDOW, 16'h0008, 12'h001, 12'h008);
			wait_pulse(200, n);
			wait_pulse(200, n);
			chk("steady gap", 16'(n > 60), 16'h1);
			dev_var_flat[63:48] <= dev_var_flat[63:48] + 16'h0020;
			wait_pulse(200, n);
			chk("step gap", 16'(n < 25), 16'h1);
		end
		i_bpl_master_model.lock(1'b0, `BPL_LK_TEMP);
		local_cfg_req <= 1'b1;
		repeat (2) @(posedge clk);
		chk("local blocked", {lock_state, local_blocked}, 16'h0003);
		i_bpl_master_model.cfg(1'b1, 1'b1, `BPL_CMD_1, `BPL_TRG_CONT, 16'h0, 12'h001, 12'h001);
		chk("other master", i_bpl_master_model.got_ref, 16'h1);
		i_bpl_master_model.lock(1'b1, `BPL_ACT_UNLOCK);
		chk("lock_state", lock_state, `BPL_LK_TEMP);
		i_bpl_master_model.lock(1'b0, `BPL_ACT_UNLOCK);
		chk("lock_state", lock_state, `BPL_LK_NONE);
		local_cfg_req <= 1'b0;
		i_bpl_master_model.lock(1'b1, `BPL_LK_PERM);
		i_bpl_master_model.cfg(1'b0, 1'b1, `BPL_CMD_1, `BPL_TRG_CONT, 16'h0, 12'h001, 12'h001);
		chk("other master", i_bpl_master_model.got_ref, 16'h1);
		do_reset;
		chk("perm restored", {lock_state, lock_owner}, 16'h0005);
		i_bpl_master_model.lock(1'b0, `BPL_ACT_UNLOCK);
		chk("lock_state", lock_state, `BPL_LK_PERM);
		i_bpl_master_model.lock(1'b1, `BPL_ACT_UNLOCK);
		chk("lock_state", lock_state, `BPL_LK_NONE);
		i_bpl_master_model.lock(1'b0, `BPL_LK_ALL);
		i_bpl_master_model.cfg(1'b0, 1'b1, `BPL_CMD_1, `BPL_TRG_CONT, 16'h0, 12'h001, 12'h001);
		chk("owner under lock all", i_bpl_master_model.got_ref, 16'h1);
		do_reset;
		chk("lock_state", lock_state, `BPL_LK_ALL);
		i_bpl_master_model.lock(1'b1, `BPL_ACT_UNLOCK);
		chk("lock_state", lock_state, `BPL_LK_NONE);
		i_bpl_master_model.lock(1'b0, `BPL_LK_TEMP);
		do_reset;
		chk("lock_state", lock_state, `BPL_LK_NONE);
		// Long tag only under the newer revision
		protocol_revision_select <= 1'b1;
		i_bpl_master_model.tag(5'h1f, 8'h5a);
		protocol_revision_select <= 1'b0;
		i_bpl_master_model.tag(5'h1f, 8'h33);
		chk("tag char", tag_read_char, 16'h005a);
		i_bpl_master_model.cfg(1'b0, 1'b1, `BPL_CMD_3, `BPL_TRG_CONT, 16'h0, 12'h001, 12'h001);
		wait_pulse(30, n);
		chk("burst on", burst_pulse, 16'h1);
		i_bpl_master_model.cfg(1'b0, 1'b0, `BPL_CMD_3, `BPL_TRG_CONT, 16'h0, 12'h001, 12'h001);
		wait_pulse(100, n);
		chk("burst off", burst_pulse, 16'h0);
		final_report;
	end
endmodule
